/* File: design/itv_pkg.sv */
// Package for the interrupt and trap vectoring block
package itv_pkg;
	localparam int NODE_W = 5;
	localparam int NUM_NODES = 32;
	localparam int TRAP_W = 7;
	localparam int VEC_W = 9;
	localparam int PRIO_W = 4;
	localparam int VEC_SHIFT = 2;
	// Trap numbers
	localparam logic [6:0] TRAP_RESET = 7'h00;
	localparam logic [6:0] TRAP_NMI = 7'h02;
	localparam logic [6:0] TRAP_OVERFLOW = 7'h04;
	localparam logic [6:0] TRAP_UNDERFLOW = 7'h06;
	localparam logic [6:0] TRAP_CLASS_B = 7'h0A;
	localparam logic [6:0] TRAP_RSV_LO = 7'h0B;
	localparam logic [6:0] TRAP_RSV_HI = 7'h0F;
	localparam logic [6:0] TRAP_FAST_EXT0 = 7'h18;
	// Fixed vectors and entry priorities
	localparam logic [8:0] VEC_RESET = 9'h000;
	localparam logic [8:0] VEC_NMI = 9'h008;
	localparam logic [8:0] VEC_CLASS_B = 9'h028;
	localparam logic [3:0] PRIO_TRAP = 4'hF;
	localparam logic [3:0] PRIO_RESET = 4'h0;
	// Peripheral node trap numbers, index 0..31
	localparam logic [6:0] NODE_TRAP [NUM_NODES] = '{
		7'h18, 7'h19, 7'h1A, 7'h1B, 7'h22, 7'h23, 7'h24, 7'h28,
		7'h29, 7'h2A, 7'h47, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F,
		7'h30, 7'h31, 7'h32, 7'h33, 7'h38, 7'h39, 7'h3A, 7'h3B,
		7'h3D, 7'h3E, 7'h3F, 7'h40, 7'h43, 7'h4D, 7'h4E, 7'h4F};
	// Trap flag register bit positions
	localparam int TF_EXT_BUS = 0;
	localparam int TF_INSTR_ACCESS = 1;
	localparam int TF_WORD_OPERAND = 2;
	localparam int TF_PROT_FAULT = 3;
	localparam int TF_UNDEF_OPCODE = 7;
	localparam int TF_UNDERFLOW = 13;
	localparam int TF_OVERFLOW = 14;
	localparam int TF_NMI = 15;
	localparam int TF_W = 16;
	localparam logic [15:0] TF_RESET = 16'h0000;
	localparam logic [15:0] TF_CLASS_A = 16'hE000;
	localparam logic [15:0] TF_CLASS_B = 16'h008F;
	// Trap priority ranks, higher wins
	localparam logic [1:0] RANK_NONE = 2'h0;
	localparam logic [1:0] RANK_B = 2'h1;
	localparam logic [1:0] RANK_A = 2'h2;

	typedef struct packed {
		logic nmi;
		logic stack_overflow;
		logic stack_underflow;
		logic undefined_opcode;
		logic protected_instr_fault;
		logic illegal_word_operand;
		logic illegal_instr_access;
		logic illegal_ext_bus;
	} itv_trap_req_t;

	typedef struct packed {
		logic valid;
		logic [6:0] trap_num;
		logic [8:0] vec_addr;
		logic [3:0] prio;
		logic is_trap;
	} itv_entry_t;
endpackage

/* File: design/itv_vectoring.sv */
// Interrupt and trap vectoring logic facing the processor core
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Every peripheral node has request flag, enable flag and vector at four times trap number.
// - Fast external inputs 0..3 vector 0x60..0x6C, trap numbers 0x18..0x1B.
// - NMI to 0x08, stack overflow 0x10, stack underflow 0x18.
// - Five class B conditions share vector 0x28, trap 0x0A, own flag bits.
// - Hardware trap branches at once, no enable flag can mask it.
// - A hardware trap sets its own bit in the trap flag register.
// - Trap pre-empts program unless a trap of equal or higher priority is in service.
// - Standard and transfer-service requests cannot interrupt a running trap service.
// - Sixteen priority levels; only higher priority pre-empts an accepted service.
// - Software trap instruction vectors to location belonging to its number.
// - Software-set request bit raises the node as if hardware had.
module itv_vectoring #(
	parameter int NODES = itv_pkg::NUM_NODES
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [NODES-1:0] hw_req,
	input wire logic [NODES-1:0] sw_set_req,
	input wire logic [NODES-1:0] sw_clr_req,
	input wire logic [NODES-1:0] node_enable,
	input wire logic [NODES*itv_pkg::PRIO_W-1:0] node_prio,
	input wire logic [NODES-1:0] node_xfer_sel,
	input wire logic global_enable,
	input wire logic [3:0] cpu_prio,
	input wire itv_pkg::itv_trap_req_t trap_req,
	input wire logic sw_trap,
	input wire logic [6:0] sw_trap_num,
	input wire logic entry_ack,
	input wire logic trap_return,
	input wire logic [15:0] tf_clear,
	output logic [NODES-1:0] node_request_bit,
	output logic [15:0] trap_flag_register,
	output itv_pkg::itv_entry_t entry,
	output logic xfer_req,
	output logic [4:0] xfer_node,
	output logic trap_active
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [8:0] vec_of(input logic [6:0] tn);
		vec_of = {tn, 2'b00};
	endfunction

	function automatic logic [1:0] rank_of(input itv_pkg::itv_trap_req_t t);
		if (t.nmi || t.stack_overflow || t.stack_underflow)
			rank_of = itv_pkg::RANK_A;
		else if (t.undefined_opcode || t.protected_instr_fault || t.illegal_word_operand ||
			t.illegal_instr_access || t.illegal_ext_bus)
			rank_of = itv_pkg::RANK_B;
		else
			rank_of = itv_pkg::RANK_NONE;
	endfunction

	// ****************************************
	// Request flags and trap flags
	// ****************************************
	logic [NODES-1:0] req_q, req_d;
	logic [15:0] tf_q, tf_d;
	logic [1:0] svc_rank_q, svc_rank_d;
	logic [15:0] tf_set;
	logic [1:0] new_rank;
	logic trap_take;
	logic [6:0] trap_num;
	logic node_take;
	logic [4:0] node_idx;
	logic [3:0] node_lvl;
	itv_pkg::itv_entry_t entry_q, entry_d;

	always_comb
	begin
		tf_set = '0;
		tf_set[itv_pkg::TF_NMI] = trap_req.nmi;
		tf_set[itv_pkg::TF_OVERFLOW] = trap_req.stack_overflow;
		tf_set[itv_pkg::TF_UNDERFLOW] = trap_req.stack_underflow;
		tf_set[itv_pkg::TF_UNDEF_OPCODE] = trap_req.undefined_opcode;
		tf_set[itv_pkg::TF_PROT_FAULT] = trap_req.protected_instr_fault;
		tf_set[itv_pkg::TF_WORD_OPERAND] = trap_req.illegal_word_operand;
		tf_set[itv_pkg::TF_INSTR_ACCESS] = trap_req.illegal_instr_access;
		tf_set[itv_pkg::TF_EXT_BUS] = trap_req.illegal_ext_bus;
		// Set wins over clear
		tf_d = (tf_q & ~tf_clear) | tf_set;
		new_rank = rank_of(trap_req);
		// taken unless a service of equal or higher rank runs
		trap_take = (new_rank != itv_pkg::RANK_NONE) && (new_rank > svc_rank_q);
		if (trap_req.nmi)
			trap_num = itv_pkg::TRAP_NMI;
		else if (trap_req.stack_overflow)
			trap_num = itv_pkg::TRAP_OVERFLOW;
		else if (trap_req.stack_underflow)
			trap_num = itv_pkg::TRAP_UNDERFLOW;
		else
			trap_num = itv_pkg::TRAP_CLASS_B;
	end

	// ****************************************
	// Node arbitration
	// ****************************************
	always_comb
	begin
		node_take = 1'b0;
		node_idx = '0;
		node_lvl = '0;
		// Set wins over clear; software set acts like hardware
		req_d = (req_q & ~sw_clr_req) | hw_req | sw_set_req;
		for (int i = 0; i < NODES; i++)
		begin
			if (req_q[i] && node_enable[i] &&
				node_prio[i*itv_pkg::PRIO_W +: itv_pkg::PRIO_W] > cpu_prio &&
				(!node_take || node_prio[i*itv_pkg::PRIO_W +: itv_pkg::PRIO_W] > node_lvl))
			begin
				node_take = 1'b1;
				node_idx = i[4:0];
				node_lvl = node_prio[i*itv_pkg::PRIO_W +: itv_pkg::PRIO_W];
			end
		end
		node_take = node_take && global_enable && (svc_rank_q == itv_pkg::RANK_NONE) && !trap_take;
		svc_rank_d = svc_rank_q;
		if (trap_return)
			svc_rank_d = itv_pkg::RANK_NONE;
		if (trap_take)
			svc_rank_d = new_rank;
		entry_d = entry_q;
		if (entry_ack)
			entry_d.valid = 1'b0;
		if (trap_take)
		begin
			entry_d.valid = 1'b1;
			entry_d.trap_num = trap_num;
			entry_d.vec_addr = vec_of(trap_num);
			entry_d.prio = itv_pkg::PRIO_TRAP;
			entry_d.is_trap = 1'b1;
		end
		else if (sw_trap && !entry_q.valid)
		begin
			entry_d.valid = 1'b1;
			entry_d.trap_num = sw_trap_num;
			entry_d.vec_addr = vec_of(sw_trap_num);
			entry_d.prio = cpu_prio;
			entry_d.is_trap = 1'b0;
		end
		else if (node_take && !entry_q.valid && !node_xfer_sel[node_idx])
		begin
			entry_d.valid = 1'b1;
			entry_d.trap_num = itv_pkg::NODE_TRAP[node_idx];
			entry_d.vec_addr = vec_of(itv_pkg::NODE_TRAP[node_idx]);
			entry_d.prio = node_lvl;
			entry_d.is_trap = 1'b0;
			req_d[node_idx] = hw_req[node_idx] | sw_set_req[node_idx];
		end
		else if (node_take && node_xfer_sel[node_idx])
			req_d[node_idx] = hw_req[node_idx] | sw_set_req[node_idx];
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			req_q <= '0;
			tf_q <= itv_pkg::TF_RESET;
			svc_rank_q <= itv_pkg::RANK_NONE;
			// reset entry at vector zero, trap zero
			entry_q <= '{valid: 1'b1, trap_num: itv_pkg::TRAP_RESET, vec_addr: itv_pkg::VEC_RESET, prio: itv_pkg::PRIO_RESET, is_trap: 1'b1};
		end
		else
		begin
			req_q <= req_d;
			tf_q <= tf_d;
			svc_rank_q <= svc_rank_d;
			entry_q <= entry_d;
		end
	end

	assign node_request_bit = req_q;
	assign trap_flag_register = tf_q;
	assign entry = entry_q;
	assign trap_active = (svc_rank_q != itv_pkg::RANK_NONE);
	assign xfer_req = node_take && node_xfer_sel[node_idx];
	assign xfer_node = node_idx;

	// ****************************************
	// Assertions
	// ****************************************
	a_trap_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
		trap_req.nmi |=> tf_q[itv_pkg::TF_NMI]) else $error("nmi flag not set");
	a_classb_vector: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(trap_take && new_rank == itv_pkg::RANK_B) |=> entry_q.vec_addr == itv_pkg::VEC_CLASS_B) else $error("class b vector");
	a_nmi_vector: assert property (@(posedge ref_clk) disable iff (!rst_b)
		trap_req.nmi && trap_take |=> entry_q.vec_addr == itv_pkg::VEC_NMI && entry_q.trap_num == itv_pkg::TRAP_NMI) else $error("nmi vector");
	a_vec_times_four: assert property (@(posedge ref_clk) disable iff (!rst_b)
		entry_q.valid |-> entry_q.vec_addr == {entry_q.trap_num, 2'b00}) else $error("vector not 4x trap");
	a_trap_unmasked: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(trap_req.nmi && svc_rank_q != itv_pkg::RANK_A) |=> entry_q.valid && entry_q.is_trap) else $error("trap masked");
	a_no_preempt_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(svc_rank_q == itv_pkg::RANK_A && !trap_return) |=> svc_rank_q == itv_pkg::RANK_A) else $error("class a pre-empted");
	a_trap_blocks_nodes: assert property (@(posedge ref_clk) disable iff (!rst_b)
		trap_active |-> !xfer_req) else $error("transfer during trap");
	a_sw_trap_prio: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(sw_trap && !trap_take && !entry_q.valid) |=> entry_q.prio == $past(cpu_prio) && !entry_q.is_trap) else $error("sw trap prio");
	a_sw_set_raises: assert property (@(posedge ref_clk) disable iff (!rst_b)
		sw_set_req[0] |=> req_q[0]) else $error("sw set lost");
	a_overflow_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
		trap_req.stack_overflow |=> tf_q[itv_pkg::TF_OVERFLOW]) else $error("overflow flag not set");
	a_node_prio_above: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(node_take && !entry_q.valid && !sw_trap && !node_xfer_sel[node_idx]) |=> entry_q.prio > $past(cpu_prio)) else $error("node prio");
	a_reserved_unused: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(entry_q.valid && entry_q.is_trap) |-> !(entry_q.trap_num inside {[itv_pkg::TRAP_RSV_LO:itv_pkg::TRAP_RSV_HI]})) else $error("reserved trap");
	a_xfer_clears_req: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(xfer_req && !hw_req[xfer_node] && !sw_set_req[xfer_node]) |=> !req_q[$past(xfer_node)]) else $error("xfer req kept");
	c_trap_entry: cover property (@(posedge ref_clk) disable iff (!rst_b) trap_take);
	c_node_entry: cover property (@(posedge ref_clk) disable iff (!rst_b) node_take && !node_xfer_sel[node_idx]);
	c_xfer: cover property (@(posedge ref_clk) disable iff (!rst_b) xfer_req);
	c_nested_trap: cover property (@(posedge ref_clk) disable iff (!rst_b) trap_take && svc_rank_q == itv_pkg::RANK_B);
	c_sw_entry: cover property (@(posedge ref_clk) disable iff (!rst_b) sw_trap && !trap_take && !entry_q.valid);
endmodule
`default_nettype wire

/* File: bench/itv_core_model.sv */
// Processor core model that accepts vector entries
`timescale 1ns/1ps
`default_nettype none
module itv_core_model (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire itv_pkg::itv_entry_t entry,
	input wire logic [3:0] ack_dly,
	output logic entry_ack,
	output itv_pkg::itv_entry_t got,
	output var int n_got
);
	logic [3:0] cnt_q;
	// Ack after a chosen delay, take the entry at the ack edge
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			entry_ack <= 1'b0;
			cnt_q <= 4'h0;
			n_got <= 0;
			got <= '0;
		end
		else if (entry_ack)
		begin
			got <= entry;
			n_got <= n_got + 1;
			entry_ack <= 1'b0;
			cnt_q <= 4'h0;
		end
		else if (entry.valid)
		begin
			if (cnt_q >= ack_dly)
				entry_ack <= 1'b1;
			else
				cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the vectoring block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk = 1'b0, rst_b = 1'b0, global_enable = 1'b0, sw_trap = 1'b0, trap_return = 1'b0;
	logic [31:0] hw_req = '0, sw_set_req = '0, sw_clr_req = '0, node_enable = '0, node_xfer_sel = '0;
	logic [127:0] node_prio = '0;
	logic [3:0] cpu_prio = 4'h0, ack_dly = 4'h1;
	logic [6:0] sw_trap_num = 7'h00, t;
	logic [15:0] tf_clear = 16'h0000, trap_flag_register;
	itv_pkg::itv_trap_req_t trap_req = '0;
	itv_pkg::itv_entry_t entry, got;
	logic entry_ack, xfer_req, trap_active;
	logic [31:0] node_request_bit;
	logic [4:0] xfer_node;
	int n_got, n_errors = 0, n_checks = 0;
	int tfb[8] = '{15, 14, 13, 7, 3, 2, 1, 0};
	logic [6:0] swn[3] = '{7'h00, 7'h0C, 7'h7F};
	itv_vectoring itv_vectoring_i (.ref_clk(ref_clk), .rst_b(rst_b), .hw_req(hw_req), .sw_set_req(sw_set_req),
		.sw_clr_req(sw_clr_req), .node_enable(node_enable), .node_prio(node_prio), .node_xfer_sel(node_xfer_sel),
		.global_enable(global_enable), .cpu_prio(cpu_prio), .trap_req(trap_req), .sw_trap(sw_trap),
		.sw_trap_num(sw_trap_num), .entry_ack(entry_ack), .trap_return(trap_return), .tf_clear(tf_clear),
		.node_request_bit(node_request_bit), .trap_flag_register(trap_flag_register), .entry(entry),
		.xfer_req(xfer_req), .xfer_node(xfer_node), .trap_active(trap_active));
	itv_core_model itv_core_model_i (.ref_clk(ref_clk), .rst_b(rst_b), .entry(entry), .ack_dly(ack_dly),
		.entry_ack(entry_ack), .got(got), .n_got(n_got));
	initial
		forever #12.5 ref_clk = ~ref_clk;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Wait for the core to take an entry, then compare it
	task automatic take(input logic [6:0] tn, input logic [8:0] v);
		int base;
		base = n_got;
		for (int i = 0; i < 60 && n_got == base; i++)
			@(negedge ref_clk);
		if (n_got == base)
		begin
			n_errors++;
			final_report();
		end
		check("trap", 32'(got.trap_num), 32'(tn));
		check("vector", 32'(got.vec_addr), 32'(v));
	endtask
	task automatic none(input int n);
		int base;
		base = n_got;
		repeat (n) @(negedge ref_clk);
		check("taken", 32'(n_got - base), 32'h0);
		check("valid", 32'(entry.valid), 32'h0);
	endtask
	task automatic pulse(input logic [31:0] set, input logic [7:0] tr, input logic [7:0] sw, input logic ret);
		@(posedge ref_clk);
		sw_set_req <= set;
		trap_req <= tr;
		sw_trap <= sw[7];
		sw_trap_num <= sw[6:0];
		trap_return <= ret;
		@(posedge ref_clk);
		sw_set_req <= 32'h0;
		trap_req <= '0;
		sw_trap <= 1'b0;
		trap_return <= 1'b0;
	endtask
	task automatic do_reset();
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		take(7'h00, 9'h000);
	endtask
	initial
	begin
		do_reset();
		for (int k = 0; k < 8; k++)
		begin
			pulse(32'h0, 8'h80 >> k, 8'h00, 1'b0);
			take(k < 3 ? 7'(2 * k + 2) : 7'h0A, k < 3 ? 9'(8 * k + 8) : 9'h028);
			check("flags", 32'(trap_flag_register), 32'h1 << tfb[k]);
			check("active", 32'(trap_active), 32'h1);
			pulse(32'h0, 8'h00, 8'h00, 1'b1);
			@(posedge ref_clk);
			tf_clear <= 16'hFFFF;
			@(posedge ref_clk);
			tf_clear <= 16'h0000;
		end
		$display("test traps done");
		pulse(32'h0, 8'h80, 8'h00, 1'b0);
		take(7'h02, 9'h008);
		@(posedge ref_clk);
		global_enable <= 1'b1;
		node_enable <= '1;
		node_prio <= {32{4'h1}};
		pulse(32'h1, 8'h10, 8'h00, 1'b0);
		none(10);
		check("flag", 32'(trap_flag_register[7]), 32'h1);
		pulse(32'h0, 8'h00, 8'h00, 1'b1);
		take(7'h18, 9'h060);
		for (int i = 1; i < 32; i++)
		begin
			t = i < 4 ? 7'h18 + 7'(i) : itv_pkg::NODE_TRAP[i];
			pulse(32'h1 << i, 8'h00, 8'h00, 1'b0);
			take(t, {t, 2'b00});
		end
		$display("test nodes done");
		@(posedge ref_clk);
		cpu_prio <= 4'h4;
		node_prio[12+:4] <= 4'h4;
		node_prio[28+:4] <= 4'h5;
		hw_req <= 32'h88;
		@(posedge ref_clk);
		hw_req <= 32'h0;
		take(7'h28, 9'h0A0);
		none(8);
		check("pending", 32'(node_request_bit[3]), 32'h1);
		@(posedge ref_clk);
		cpu_prio <= 4'h3;
		take(7'h1B, 9'h06C);
		$display("test priority done");
		@(posedge ref_clk);
		cpu_prio <= 4'h9;
		for (int j = 0; j < 3; j++)
		begin
			pulse(32'h0, 8'h00, {1'b1, swn[j]}, 1'b0);
			take(swn[j], {swn[j], 2'b00});
			check("prio", 32'(got.prio), 32'h9);
		end
		$display("test software traps done");
		@(posedge ref_clk);
		node_xfer_sel <= 32'h200;
		cpu_prio <= 4'h0;
		pulse(32'h200, 8'h00, 8'h00, 1'b0);
		for (int i = 0; i < 20 && xfer_req !== 1'b1; i++)
			@(negedge ref_clk);
		check("xfer", 32'(xfer_req), 32'h1);
		if (xfer_req !== 1'b1)
			final_report();
		check("xfer node", 32'(xfer_node), 32'h9);
		none(5);
		$display("test transfer done");
		@(posedge ref_clk);
		node_enable[5] <= 1'b0;
		pulse(32'h20, 8'h00, 8'h00, 1'b0);
		none(6);
		check("masked", 32'(node_request_bit[5]), 32'h1);
		@(posedge ref_clk);
		sw_clr_req <= 32'h20;
		@(posedge ref_clk);
		sw_clr_req <= 32'h0;
		node_enable[5] <= 1'b1;
		@(negedge ref_clk);
		check("cleared", 32'(node_request_bit[5]), 32'h0);
		none(4);
		$display("test enable done");
		ack_dly <= 4'hF;
		do_reset();
		pulse(32'h0, 8'h10, 8'h00, 1'b0);
		pulse(32'h0, 8'h80, 8'h00, 1'b0);
		take(7'h02, 9'h008);
		$display("test preemption done");
		final_report();
	end
endmodule
`default_nettype wire
